// ===== hw/dcf_fifo_ctrl.sv
// Dual-clock FIFO control logic with APB access to offsets and status
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - master reset rewinds pointers, sets almost flags
// - mode pin low: standard, empty low, full high
// - mode pin high: fall-through, ready high, in-ready low
// - load pin low: offsets 127, parallel loading
// - load pin high: offsets 1023, serial loading
// - offsets always readable in parallel
// - master reset zeroes output; required after power-up
// - partial reset rewinds pointers, keeps mode
// - partial reset keeps offsets, method; zeroes output
// - replay low at edge starts setup
// - standard replay: empty low, then high
// - fall-through replay: ready high, then first word
// - fall-through first word after three edges
// - mode pin is serial input if serial
// - write stores word unless full
// - write side only drives half-full low
// - read side only drives half-full high
// - full low when full, high two cycles later
// - in-ready high when full, low two cycles later
// - empty high two cycles after write
module dcf_fifo_ctrl #(
    parameter int DEPTH = dcf_pkg::DEPTH_SMALL
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic fall_through_sel_serial_in,
    input wire logic offset_load_n,
    input wire logic serial_en_n,
    input wire logic replay_n,
    input wire logic wr_en_n,
    input wire logic [dcf_pkg::DATA_W-1:0] wr_data,
    input wire logic rd_en_n,
    output logic [dcf_pkg::DATA_W-1:0] rd_data,
    output logic empty_n,
    output logic full_n,
    output logic output_ready_n,
    output logic input_ready_n,
    output logic almost_empty_n,
    output logic almost_full_n,
    output logic half_full_n
);
    // Pointers carry one bit beyond the address so full and empty stay apart
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int PTR_W = ADDR_W + 1;
    localparam logic [PTR_W-1:0] CAP = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0] HALF = PTR_W'(DEPTH / 2);
    localparam logic [PTR_W-1:0] ONE = PTR_W'(1);

    typedef struct packed {
        logic mst_rst_s1;
        logic mst_rst_s2;
        logic part_rst_s1;
        logic part_rst_s2;
        logic ft_s1;
        logic ft_s2;
        logic load_s1;
        logic load_s2;
        logic sen_s1;
        logic sen_s2;
        logic fall_through;
        logic serial_method;
        dcf_pkg::dcf_state_t state;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] rptr;
        logic [PTR_W-1:0] wptr_d1;
        logic [PTR_W-1:0] wptr_d2;
        logic [PTR_W-1:0] rptr_d1;
        logic [dcf_pkg::DATA_W-1:0] out_q;
        logic empty_n;
        logic full_n;
        logic ready_n;
        logic in_ready_n;
        logic almost_empty_n;
        logic almost_full_n;
        logic half_full_n;
        logic [dcf_pkg::OFS_W-1:0] empty_ofs;
        logic [dcf_pkg::OFS_W-1:0] full_ofs;
        logic apb_rdy;
        logic apb_err;
        logic [31:0] prdata;
    } dcf_state_s_t;

    dcf_state_s_t s_r;
    dcf_state_s_t s_nxt;
    logic [dcf_pkg::DATA_W-1:0] mem [DEPTH];
    logic [dcf_pkg::DATA_W-1:0] mem_rd;
    logic wr_fire;
    logic [PTR_W-1:0] wr_ptr_new;
    logic [PTR_W-1:0] wr_count;
    logic [PTR_W-1:0] rd_count;
    logic [PTR_W-1:0] ae_limit;
    logic rd_fire;
    logic acc;
    logic [31:0] rd_word;
    logic hit;
    logic wr_ok;

    // Read side trails the write pointer by one edge (two in fall-through), so no word is read as it lands
    assign mem_rd = mem[s_r.rptr[ADDR_W-1:0]];

    ////////////////////////////////////////////////////////////////////////////
    // Storage array: no reset, a 64K array cannot be cleared in one cycle
    always_ff @(posedge pclk) begin
        if (wr_fire) begin
            mem[s_r.wptr[ADDR_W-1:0]] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        wr_ptr_new = s_r.wptr;
        wr_count = '0;
        rd_count = '0;
        ae_limit = '0;
        acc = 1'b0;
        rd_word = 32'h00000000;
        hit = 1'b0;
        wr_ok = 1'b0;

        // Pin synchronisers: the first stage feeds only the second
        // Straps must be steady at the last edge that samples master reset low; both pass the same two stages
        s_nxt.mst_rst_s1 = master_reset_n;
        s_nxt.mst_rst_s2 = s_r.mst_rst_s1;
        s_nxt.part_rst_s1 = partial_reset_n;
        s_nxt.part_rst_s2 = s_r.part_rst_s1;
        s_nxt.ft_s1 = fall_through_sel_serial_in;
        s_nxt.ft_s2 = s_r.ft_s1;
        s_nxt.load_s1 = offset_load_n;
        s_nxt.load_s2 = s_r.load_s1;
        s_nxt.sen_s1 = serial_en_n;
        s_nxt.sen_s2 = s_r.sen_s1;

        // Pointer delays (two stages on the write pointer, one on the read pointer) model the cross-side flag latency
        s_nxt.wptr_d1 = s_r.wptr;
        s_nxt.wptr_d2 = s_r.wptr_d1;
        s_nxt.rptr_d1 = s_r.rptr;

        //////////////////////////////////////////////////////////////////////
        // Write side
        if (s_r.fall_through) begin
            wr_fire = !wr_en_n && !s_r.in_ready_n;
        end else begin
            wr_fire = !wr_en_n && s_r.full_n;
        end
        wr_ptr_new = s_r.wptr + (wr_fire ? ONE : '0);
        s_nxt.wptr = wr_ptr_new;
        // Read pointer seen one cycle late, so a read frees space two cycles on
        wr_count = wr_ptr_new - s_r.rptr_d1;
        if (s_r.fall_through) begin
            // Output register holds the extra word beyond CAP
            s_nxt.in_ready_n = (wr_count == CAP);
        end else begin
            s_nxt.full_n = (wr_count != CAP);
        end
        s_nxt.almost_full_n = (wr_count < CAP - PTR_W'(s_r.full_ofs));
        if (wr_fire && wr_count > HALF) begin
            s_nxt.half_full_n = 1'b0;
        end

        //////////////////////////////////////////////////////////////////////
        // Read side
        case (s_r.state)
            dcf_pkg::DCF_RUN: begin
                if (!replay_n) begin
                    // Rewind; reader keeps both enables high meanwhile
                    s_nxt.state = dcf_pkg::DCF_REPLAY;
                    s_nxt.rptr = '0;
                    if (s_r.fall_through) begin
                        s_nxt.ready_n = 1'b1;
                    end else begin
                        s_nxt.empty_n = 1'b0;
                    end
                end else if (s_r.fall_through) begin
                    // Fresh data seen two cycles late: first word lands on the third edge
                    if (s_r.wptr_d2 != s_r.rptr && (s_r.ready_n || !rd_en_n)) begin
                        rd_fire = 1'b1;
                        s_nxt.out_q = mem_rd;
                        s_nxt.rptr = s_r.rptr + ONE;
                        s_nxt.ready_n = 1'b0;
                    end else if (!rd_en_n && !s_r.ready_n) begin
                        // Last word taken: data stays, ready rises
                        s_nxt.ready_n = 1'b1;
                    end
                end else begin
                    if (!rd_en_n && s_r.empty_n) begin
                        rd_fire = 1'b1;
                        s_nxt.out_q = mem_rd;
                        s_nxt.rptr = s_r.rptr + ONE;
                    end
                    s_nxt.empty_n = (s_r.wptr_d1 != s_nxt.rptr);
                end
            end
            dcf_pkg::DCF_REPLAY: begin
                s_nxt.state = dcf_pkg::DCF_RUN;
                if (!s_r.fall_through) begin
                    s_nxt.empty_n = (s_r.wptr_d1 != s_r.rptr);
                end
            end
            default: begin
                s_nxt.state = dcf_pkg::DCF_RUN;
            end
        endcase
        rd_count = s_r.wptr_d1 - s_nxt.rptr;
        if (s_r.fall_through) begin
            rd_count = rd_count + (s_nxt.ready_n ? '0 : ONE);
            ae_limit = PTR_W'(s_r.empty_ofs) + ONE;
        end else begin
            ae_limit = PTR_W'(s_r.empty_ofs);
        end
        s_nxt.almost_empty_n = (rd_count > ae_limit);
        if ((rd_fire || s_r.state == dcf_pkg::DCF_REPLAY) && rd_count <= HALF) begin
            s_nxt.half_full_n = 1'b1;
        end

        //////////////////////////////////////////////////////////////////////
        // Serial offset loading through the shared mode pin
        if (s_r.serial_method && !s_r.load_s2 && !s_r.sen_s2) begin
            {s_nxt.full_ofs, s_nxt.empty_ofs} = {s_r.full_ofs[dcf_pkg::OFS_W-2:0],
                                                  s_r.empty_ofs, s_r.ft_s2};
        end

        //////////////////////////////////////////////////////////////////////
        // APB slave: one wait state so read data comes from a flop
        acc = psel && penable && !s_r.apb_rdy;
        s_nxt.apb_rdy = acc;
        case (paddr)
            dcf_pkg::ADDR_EMPTY_OFS: begin
                hit = 1'b1;
                rd_word = 32'(s_r.empty_ofs);
            end
            dcf_pkg::ADDR_FULL_OFS: begin
                hit = 1'b1;
                rd_word = 32'(s_r.full_ofs);
            end
            dcf_pkg::ADDR_STATUS: begin
                hit = !pwrite;
                rd_word[dcf_pkg::ST_FALL_THROUGH] = s_r.fall_through;
                rd_word[dcf_pkg::ST_SERIAL] = s_r.serial_method;
                rd_word[dcf_pkg::ST_EMPTY_N] = s_r.empty_n;
                rd_word[dcf_pkg::ST_FULL_N] = s_r.full_n;
                rd_word[dcf_pkg::ST_READY_N] = s_r.ready_n;
                rd_word[dcf_pkg::ST_IN_READY_N] = s_r.in_ready_n;
                rd_word[dcf_pkg::ST_ALMOST_EMPTY_N] = s_r.almost_empty_n;
                rd_word[dcf_pkg::ST_ALMOST_FULL_N] = s_r.almost_full_n;
                rd_word[dcf_pkg::ST_HALF_FULL_N] = s_r.half_full_n;
                rd_word[dcf_pkg::ST_REPLAY] = (s_r.state == dcf_pkg::DCF_REPLAY);
            end
            dcf_pkg::ADDR_LEVEL: begin
                hit = !pwrite;
                rd_word = 32'(s_r.wptr - s_r.rptr_d1);
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        // Parallel writes are refused when serial loading was latched
        wr_ok = hit && !(pwrite && s_r.serial_method);
        if (acc) begin
            s_nxt.prdata = pwrite ? 32'h00000000 : rd_word;
            s_nxt.apb_err = !wr_ok;
        end
        // Write lands at the edge that completes the transfer
        if (psel && penable && s_r.apb_rdy && pwrite && !s_r.apb_err && pstrb != 4'h0) begin
            if (paddr == dcf_pkg::ADDR_EMPTY_OFS) begin
                s_nxt.empty_ofs = pwdata[dcf_pkg::OFS_W-1:0];
            end else begin
                s_nxt.full_ofs = pwdata[dcf_pkg::OFS_W-1:0];
            end
        end

        //////////////////////////////////////////////////////////////////////
        // Resets from pins override the pointer, flag and output logic above, not the APB handshake; master reset also overrides APB and serial offset writes
        if (!s_r.mst_rst_s2 || !s_r.part_rst_s2) begin
            if (!s_r.mst_rst_s2) begin
                s_nxt.fall_through = s_r.ft_s2;
                s_nxt.serial_method = s_r.load_s2;
                s_nxt.empty_ofs = s_r.load_s2 ? dcf_pkg::OFS_DEF_SER : dcf_pkg::OFS_DEF_PAR;
                s_nxt.full_ofs = s_r.load_s2 ? dcf_pkg::OFS_DEF_SER : dcf_pkg::OFS_DEF_PAR;
            end
            // Partial reset keeps mode, method and offsets
            s_nxt.state = dcf_pkg::DCF_RUN;
            s_nxt.wptr = '0;
            s_nxt.rptr = '0;
            s_nxt.wptr_d1 = '0;
            s_nxt.wptr_d2 = '0;
            s_nxt.rptr_d1 = '0;
            s_nxt.out_q = dcf_pkg::OUT_RESET;
            s_nxt.empty_n = 1'b0;
            s_nxt.full_n = 1'b1;
            s_nxt.ready_n = 1'b1;
            s_nxt.in_ready_n = 1'b0;
            s_nxt.almost_empty_n = 1'b0;
            s_nxt.almost_full_n = 1'b1;
            s_nxt.half_full_n = 1'b1;
            wr_fire = 1'b0;
            rd_fire = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Synchroniser stages come up low, so leaving reset runs a master reset too
            s_r.mst_rst_s1 <= 1'b0;
            s_r.mst_rst_s2 <= 1'b0;
            s_r.part_rst_s1 <= 1'b0;
            s_r.part_rst_s2 <= 1'b0;
            s_r.ft_s1 <= 1'b0;
            s_r.ft_s2 <= 1'b0;
            s_r.load_s1 <= 1'b0;
            s_r.load_s2 <= 1'b0;
            s_r.sen_s1 <= 1'b0;
            s_r.sen_s2 <= 1'b0;
            s_r.fall_through <= 1'b0;
            s_r.serial_method <= 1'b0;
            s_r.state <= dcf_pkg::DCF_RUN;
            s_r.wptr <= '0;
            s_r.rptr <= '0;
            s_r.wptr_d1 <= '0;
            s_r.wptr_d2 <= '0;
            s_r.rptr_d1 <= '0;
            s_r.out_q <= dcf_pkg::OUT_RESET;
            s_r.empty_n <= 1'b0;
            s_r.full_n <= 1'b1;
            s_r.ready_n <= 1'b1;
            s_r.in_ready_n <= 1'b0;
            s_r.almost_empty_n <= 1'b0;
            s_r.almost_full_n <= 1'b1;
            s_r.half_full_n <= 1'b1;
            s_r.empty_ofs <= dcf_pkg::OFS_DEF_PAR;
            s_r.full_ofs <= dcf_pkg::OFS_DEF_PAR;
            s_r.apb_rdy <= 1'b0;
            s_r.apb_err <= 1'b0;
            s_r.prdata <= 32'h00000000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.apb_rdy;
    assign pslverr = s_r.apb_rdy && s_r.apb_err;
    assign rd_data = s_r.out_q;
    // Flag pins of the unselected mode rest at their reset levels
    assign empty_n = s_r.fall_through ? 1'b0 : s_r.empty_n;
    assign full_n = s_r.fall_through ? 1'b1 : s_r.full_n;
    assign output_ready_n = s_r.fall_through ? s_r.ready_n : 1'b1;
    assign input_ready_n = s_r.fall_through ? s_r.in_ready_n : 1'b0;
    assign almost_empty_n = s_r.almost_empty_n;
    assign almost_full_n = s_r.almost_full_n;
    assign half_full_n = s_r.half_full_n;
endmodule

// ===== hw/dcf_pkg.sv
// Package: constants and types of the dual-clock FIFO control block
package dcf_pkg;
    localparam int DATA_W = 9;
    localparam int DEPTH_SMALL = 65536;
    localparam int DEPTH_LARGE = 131072;
    localparam int OFS_W = 17;
    localparam logic [OFS_W-1:0] OFS_DEF_PAR = 17'h0007F;
    localparam logic [OFS_W-1:0] OFS_DEF_SER = 17'h003FF;
    localparam logic [DATA_W-1:0] OUT_RESET = 9'h000;
    // APB register map, byte addresses
    localparam logic [7:0] ADDR_EMPTY_OFS = 8'h00;
    localparam logic [7:0] ADDR_FULL_OFS = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_LEVEL = 8'h0C;
    // STATUS field positions
    localparam int ST_FALL_THROUGH = 0;
    localparam int ST_SERIAL = 1;
    localparam int ST_EMPTY_N = 2;
    localparam int ST_FULL_N = 3;
    localparam int ST_READY_N = 4;
    localparam int ST_IN_READY_N = 5;
    localparam int ST_ALMOST_EMPTY_N = 6;
    localparam int ST_ALMOST_FULL_N = 7;
    localparam int ST_HALF_FULL_N = 8;
    localparam int ST_REPLAY = 9;
    typedef enum logic {
        DCF_RUN,
        DCF_REPLAY
    } dcf_state_t;
endpackage

// ===== tb/dcf_fifo_ctrl_properties.sv
// Checker of reset values, mode flags and flag latencies of the FIFO control
`timescale 1ns/100ps
module dcf_fifo_ctrl_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic fall_through_sel_serial_in,
    input wire logic replay_n,
    input wire logic wr_en_n,
    input wire logic rd_en_n,
    input wire logic [dcf_pkg::DATA_W-1:0] rd_data,
    input wire logic empty_n,
    input wire logic full_n,
    input wire logic output_ready_n,
    input wire logic input_ready_n,
    input wire logic almost_empty_n,
    input wire logic almost_full_n,
    input wire logic half_full_n
);
    logic mode_ft_r;
    logic [3:0] calm_r;
    logic calm;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Reset pins pass a synchroniser, so both must be high for a while to count as calm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ft_r <= 1'b0;
            calm_r <= 4'h0;
        end else begin
            calm_r <= {calm_r[2:0], master_reset_n & partial_reset_n};
            if (!master_reset_n) begin
                mode_ft_r <= fall_through_sel_serial_in;
            end
        end
    end
    assign calm = &calm_r & master_reset_n & partial_reset_n;
    ////////////////////////////////////////////////////////////////////////////
    mr_flags_a: assert property (
        !master_reset_n [*4] |-> !almost_empty_n && almost_full_n && half_full_n
        && rd_data == dcf_pkg::OUT_RESET) else $error("master reset flags wrong");
    std_mode_a: assert property (
        !master_reset_n [*4] ##0 !fall_through_sel_serial_in |-> !empty_n && full_n
        && output_ready_n && !input_ready_n) else $error("standard reset flags wrong");
    ft_mode_a: assert property (
        !master_reset_n [*4] ##0 fall_through_sel_serial_in |-> output_ready_n
        && !input_ready_n) else $error("fall-through reset flags wrong");
    pr_flags_a: assert property (
        !partial_reset_n [*4] |-> !almost_empty_n && almost_full_n && half_full_n
        && rd_data == dcf_pkg::OUT_RESET
        && (mode_ft_r ? output_ready_n && !input_ready_n : !empty_n && full_n))
        else $error("partial reset flags wrong");
    std_hold_a: assert property (
        !mode_ft_r && calm && rd_en_n |=> $stable(rd_data))
        else $error("output moved without read enable");
    empty_rise_a: assert property (
        !mode_ft_r && calm && !wr_en_n && full_n && !empty_n && replay_n && $past(replay_n)
        && $past(wr_en_n) && $past(wr_en_n, 2) |-> ##1 !empty_n [*2] ##1 empty_n)
        else $error("empty flag latency wrong");
    ft_first_a: assert property (
        mode_ft_r && calm && !wr_en_n && !input_ready_n && output_ready_n && replay_n
        && $past(replay_n) && $past(wr_en_n) && $past(wr_en_n, 2) && $past(wr_en_n, 3)
        && $past(replay_n, 2) |-> ##1 output_ready_n [*3] ##1 !output_ready_n)
        else $error("first word latency wrong");
    replay_std_a: assert property (
        !mode_ft_r && calm && !replay_n && rd_en_n && wr_en_n |=> !empty_n)
        else $error("empty flag not low in replay");
    replay_ft_a: assert property (
        mode_ft_r && calm && !replay_n && rd_en_n && wr_en_n |=> output_ready_n)
        else $error("ready flag not high in replay");
endmodule
bind dcf_fifo_ctrl dcf_fifo_ctrl_properties u_props (.pclk(pclk), .presetn(presetn),
    .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
    .fall_through_sel_serial_in(fall_through_sel_serial_in), .replay_n(replay_n),
    .wr_en_n(wr_en_n), .rd_en_n(rd_en_n), .rd_data(rd_data), .empty_n(empty_n),
    .full_n(full_n), .output_ready_n(output_ready_n), .input_ready_n(input_ready_n),
    .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n), .half_full_n(half_full_n));

// ===== tb/dcf_partner.sv
// Behavioural writer and reader on the far side of the FIFO control
`timescale 1ns/100ps
module dcf_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_req,
    input wire logic [dcf_pkg::DATA_W-1:0] wr_val,
    input wire logic rd_req,
    input wire logic replay_req,
    output logic wr_en_n,
    output logic [dcf_pkg::DATA_W-1:0] wr_data,
    output logic rd_en_n,
    output logic replay_n
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_en_n <= 1'b1;
            rd_en_n <= 1'b1;
            replay_n <= 1'b1;
            wr_data <= 9'h000;
        end else begin
            // Enables stay idle whenever a replay is asked for
            wr_en_n <= !wr_req || replay_req;
            rd_en_n <= !rd_req || replay_req;
            replay_n <= !replay_req;
            // Idle data toggles so a stale word never looks valid
            wr_data <= wr_req ? wr_val : ~wr_data;
        end
    end
endmodule

// ===== tb/test_dual_clock_fifo_control.sv
// Self-checking testbench of the dual-clock FIFO control block
`timescale 1ns/100ps
module test_dual_clock_fifo_control;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic master_reset_n, partial_reset_n, fall_through_sel_serial_in, offset_load_n;
    logic serial_en_n, replay_n, wr_en_n, rd_en_n, wr_req, rd_req, replay_req;
    logic [8:0] wr_data, wr_val, rd_data;
    logic empty_n, full_n, output_ready_n, input_ready_n;
    logic almost_empty_n, almost_full_n, half_full_n;
    int n_errors = 0;
    int tests_run = 0;
    dcf_fifo_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
        .fall_through_sel_serial_in(fall_through_sel_serial_in),
        .offset_load_n(offset_load_n), .serial_en_n(serial_en_n), .replay_n(replay_n),
        .wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n), .rd_data(rd_data),
        .empty_n(empty_n), .full_n(full_n), .output_ready_n(output_ready_n),
        .input_ready_n(input_ready_n), .almost_empty_n(almost_empty_n),
        .almost_full_n(almost_full_n), .half_full_n(half_full_n));
    dcf_partner u_partner (.pclk(pclk), .presetn(presetn), .wr_req(wr_req), .wr_val(wr_val),
        .rd_req(rd_req), .replay_req(replay_req), .wr_en_n(wr_en_n), .wr_data(wr_data),
        .rd_en_n(rd_en_n), .replay_n(replay_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // APB transfer; the answer is taken at the rising edge that samples pready high
    task automatic reg_chk(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                           input logic [31:0] exp, input logic exp_err, input string name);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        if (!wr && !exp_err) chk(name, prdata, exp);
        chk({name, "_err"}, pslverr, exp_err);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mreset(input logic ft, input logic ld);
        @(posedge pclk);
        fall_through_sel_serial_in <= ft;
        offset_load_n <= ld;
        master_reset_n <= 1'b0;
        cyc(6);
        master_reset_n <= 1'b1;
        cyc(5);
        @(negedge pclk);
    endtask
    task automatic wr_word(input logic [8:0] v);
        @(posedge pclk);
        wr_req <= 1'b1;
        wr_val <= v;
        @(posedge pclk);
        wr_req <= 1'b0;
    endtask
    task automatic rd_word(input logic [8:0] exp, input string name);
        @(posedge pclk);
        rd_req <= 1'b1;
        @(posedge pclk);
        rd_req <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        chk(name, rd_data, exp);
    endtask
    task automatic replay();
        @(posedge pclk);
        replay_req <= 1'b1;
        @(posedge pclk);
        replay_req <= 1'b0;
        cyc(3);
        @(negedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_std();
        mreset(1'b0, 1'b0);
        chk("empty_full", {empty_n, full_n}, 2'b01);
        chk("almost_half", {almost_empty_n, almost_full_n, half_full_n}, 3'b011);
        chk("rd_data", rd_data, dcf_pkg::OUT_RESET);
        reg_chk(1'b0, dcf_pkg::ADDR_FULL_OFS, 32'h0, 32'h7F, 1'b0, "full_ofs");
        reg_chk(1'b0, 8'h10, 32'h0, 32'h0, 1'b1, "unmapped");
        wr_word(9'h1A5);
        wr_word(9'h05A);
        wr_word(9'h1FF);
        cyc(3);
        @(negedge pclk);
        chk("empty_n", empty_n, 1'b1);
        reg_chk(1'b0, dcf_pkg::ADDR_LEVEL, 32'h0, 32'h3, 1'b0, "level");
        rd_word(9'h1A5, "rd0");
        rd_word(9'h05A, "rd1");
        rd_word(9'h1FF, "rd2");
        chk("empty_n", empty_n, 1'b0);
        rd_word(9'h1FF, "rd_empty");
        replay();
        chk("empty_n", empty_n, 1'b1);
        chk("rd_hold", rd_data, 9'h1FF);
        rd_word(9'h1A5, "replay0");
        $display("test std done");
    endtask
    task automatic t_partial();
        reg_chk(1'b1, dcf_pkg::ADDR_EMPTY_OFS, 32'h155, 32'h0, 1'b0, "ofs_wr");
        @(posedge pclk);
        partial_reset_n <= 1'b0;
        cyc(6);
        partial_reset_n <= 1'b1;
        cyc(5);
        @(negedge pclk);
        chk("empty_full", {empty_n, full_n}, 2'b01);
        chk("almost_half", {almost_empty_n, almost_full_n, half_full_n}, 3'b011);
        chk("rd_data", rd_data, dcf_pkg::OUT_RESET);
        reg_chk(1'b0, dcf_pkg::ADDR_EMPTY_OFS, 32'h0, 32'h155, 1'b0, "ofs_kept");
        $display("test partial done");
    endtask
    task automatic t_ft();
        logic [33:0] ser;
        mreset(1'b1, 1'b1);
        chk("ready_flags", {output_ready_n, input_ready_n}, 2'b10);
        reg_chk(1'b0, dcf_pkg::ADDR_FULL_OFS, 32'h0, 32'h3FF, 1'b0, "full_ofs");
        reg_chk(1'b1, dcf_pkg::ADDR_EMPTY_OFS, 32'h20, 32'h0, 1'b1, "par_wr");
        reg_chk(1'b0, dcf_pkg::ADDR_EMPTY_OFS, 32'h0, 32'h3FF, 1'b0, "empty_ofs");
        wr_word(9'h0C3);
        wr_word(9'h13C);
        cyc(4);
        @(negedge pclk);
        chk("ready_n", output_ready_n, 1'b0);
        chk("first", rd_data, 9'h0C3);
        rd_word(9'h13C, "second");
        replay();
        chk("ready_n", output_ready_n, 1'b0);
        chk("replay0", rd_data, 9'h0C3);
        // Full offset shifts in first, empty offset LSB last
        ser = {17'h00123, 17'h00045};
        for (int i = 33; i >= 0; i--) begin
            @(posedge pclk);
            offset_load_n <= 1'b0;
            serial_en_n <= 1'b0;
            fall_through_sel_serial_in <= ser[i];
        end
        @(posedge pclk);
        offset_load_n <= 1'b1;
        serial_en_n <= 1'b1;
        cyc(2);
        reg_chk(1'b0, dcf_pkg::ADDR_FULL_OFS, 32'h0, 32'h123, 1'b0, "ser_full");
        reg_chk(1'b0, dcf_pkg::ADDR_EMPTY_OFS, 32'h0, 32'h45, 1'b0, "ser_empty");
        $display("test ft done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, wr_req, rd_req, replay_req} = 7'h00;
        {paddr, pwdata, wr_val, fall_through_sel_serial_in, offset_load_n} = '0;
        {master_reset_n, partial_reset_n, serial_en_n} = 3'h7;
        pstrb = 4'hF;
        cyc(5);
        presetn <= 1'b1;
        t_std();
        t_partial();
        t_ft();
        test_done();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        cyc(3000);
        n_errors++;
        $display("watchdog expired");
        test_done();
    end
endmodule
